// [csp_pkg.sv]
package csp_pkg;
    // clock rates
    localparam int CLK_HZ = 100_000_000;
    localparam int XTAL_HZ = 32768;
    localparam int RC_350_HZ = 350_000;
    localparam int RC_650_HZ = 650_000;
    // half-period counts of each oscillator at the core clock rate
    localparam int XTAL_HALF_CYC = CLK_HZ / (2 * XTAL_HZ);
    localparam int RC_350_HALF_CYC = CLK_HZ / (2 * RC_350_HZ);
    localparam int RC_650_HALF_CYC = CLK_HZ / (2 * RC_650_HZ);
    // pre-divider geometry
    localparam int DIV_STAGES = 15;
    localparam int CLR_LOW_STAGE = 10;
    localparam int TAP14_BIT = 13;
    localparam int PRE_DIV_DEFAULT = 1;
    localparam logic [11:0] CLR_OPERAND = 12'h100;
    // peripheral taps: system, halver/tripler, lcd alternation, sound, debounce
    localparam int NUM_TAPS = 5;
    localparam int PERIPH_TAP [NUM_TAPS] = '{0, 3, 9, 2, 13};
    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h8;
    localparam logic [3:0] REG_COUNT = 4'hc;
    // field positions
    localparam int CTRL_IRQ_EN_BIT = 0;
    localparam int CTRL_WAKE_EN_BIT = 1;
    localparam int ST_HRF_BIT = 0;
    localparam int ST_WAKE_START_CONDITION_FLAG_BIT = 1;
    localparam int FLD_W = 2;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [1:0] STATUS_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    // build options
    typedef enum logic [0:0] {SRC_CRYSTAL = 1'b0, SRC_RC = 1'b1} csp_src_type;
    typedef enum logic [0:0] {RES_INTERNAL = 1'b0, RES_EXTERNAL = 1'b1} csp_res_type;
    typedef enum logic [0:0] {RC_FREQ_350 = 1'b0, RC_FREQ_650 = 1'b1} csp_rcf_type;
    // bus handshake states
    typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} csp_bus_type;
endpackage

// [csp_div_if.sv]
`timescale 1ns/100ps
interface csp_div_if;
    logic fall_en;
    logic clr_upper;
    logic [csp_pkg::DIV_STAGES-1:0] count;
    logic tap14_rise;
    modport div (input fall_en, input clr_upper, output count, output tap14_rise);
    modport ctl (output fall_en, output clr_upper, input count, input tap14_rise);
endinterface

// [csp_predivider.sv]
`timescale 1ns/100ps
module csp_predivider (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    csp_div_if.div div_io
);
    import csp_pkg::*;

    logic [DIV_STAGES-1:0] count_ff;
    logic [DIV_STAGES-1:0] nxt_count;
    logic tap_ff;
    logic nxt_tap;

    // ripple count on the falling edge of the input clock, upper clear wins
    always_comb begin
        nxt_count = count_ff;
        if (div_io.fall_en) begin
            nxt_count = count_ff + 15'h1;
        end
        if (div_io.clr_upper) begin
            nxt_count[DIV_STAGES-1:CLR_LOW_STAGE] = '0;
        end
        nxt_tap = ~count_ff[TAP14_BIT] & nxt_count[TAP14_BIT];
    end

    // state registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_ff <= '0;
            tap_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tap_ff <= nxt_tap;
        end
    end

    assign div_io.count = count_ff;
    assign div_io.tap14_rise = tap_ff;

    default clocking dck @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    chk_count_step: assert property (div_io.fall_en && !div_io.clr_upper |=> count_ff == $past(count_ff) + 15'h1)
        else $error("pre-divider did not advance by one");
    chk_count_hold: assert property (!div_io.fall_en && !div_io.clr_upper |=> $stable(count_ff))
        else $error("pre-divider moved without a falling input edge");
    chk_upper_clear: assert property (div_io.clr_upper |=> count_ff[DIV_STAGES-1:CLR_LOW_STAGE] == 5'h0)
        else $error("upper stages not cleared");
    chk_tap_rise: assert property (tap_ff |-> count_ff[TAP14_BIT] && !$past(count_ff[TAP14_BIT]))
        else $error("tap fourteen request without a rising stage");
    cov_upper_clear: cover property (div_io.clr_upper && count_ff[TAP14_BIT]);
endmodule // csp_predivider

// [csp_top.sv]
`timescale 1ns/100ps
module csp_top #(
    parameter csp_pkg::csp_src_type CLK_SOURCE = csp_pkg::SRC_CRYSTAL,
    parameter csp_pkg::csp_res_type RC_RESISTOR = csp_pkg::RES_INTERNAL,
    parameter csp_pkg::csp_rcf_type RC_FREQ = csp_pkg::RC_FREQ_350,
    parameter int PRE_DIV = csp_pkg::PRE_DIV_DEFAULT,
    parameter int XTAL_HALF = csp_pkg::XTAL_HALF_CYC,
    parameter int RC_350_HALF = csp_pkg::RC_350_HALF_CYC,
    parameter int RC_650_HALF = csp_pkg::RC_650_HALF_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic stop_mode_in,
    input wire logic ext_rc_osc_in,
    input wire logic prescaler_clear_instruction_in,
    input wire logic [11:0] clear_operand_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [csp_pkg::NUM_TAPS-1:0] periph_clk_out,
    output logic divider_input_clock_out,
    output logic predivider_irq_out,
    output logic halt_release_out,
    output logic wake_start_condition_flag_out,
    output logic irq_out
);
    import csp_pkg::*;

    // static build-time selections
    localparam bit IS_CRYSTAL = (CLK_SOURCE == SRC_CRYSTAL);
    localparam bit USE_EXT = !IS_CRYSTAL && (RC_RESISTOR == RES_EXTERNAL);
    localparam int RC_HALF = (RC_FREQ == RC_FREQ_650) ? RC_650_HALF : RC_350_HALF;
    localparam logic [11:0] HALF_SEL = 12'(IS_CRYSTAL ? XTAL_HALF : RC_HALF);
    localparam logic [3:0] PRE_HALF = 4'((PRE_DIV > 1) ? (PRE_DIV / 2 - 1) : 0);

    csp_div_if div_if ();

    // oscillator state
    logic [11:0] osc_cnt_ff;
    logic [11:0] nxt_osc_cnt;
    logic ext_ff;
    logic nxt_ext;
    logic base_ff;
    logic nxt_base;
    logic base_prev_ff;
    logic base_fall;
    // input clock divider state
    logic [3:0] pre_cnt_ff;
    logic [3:0] nxt_pre_cnt;
    logic din_ff;
    logic nxt_din;
    logic din_prev_ff;
    // event and register state
    logic [FLD_W-1:0] ctrl_ff;
    logic [FLD_W-1:0] nxt_ctrl;
    logic [FLD_W-1:0] status_ff;
    logic [FLD_W-1:0] nxt_status;
    logic [FLD_W-1:0] mask_ff;
    logic [FLD_W-1:0] nxt_mask;
    logic irq_ff;
    logic nxt_irq;
    logic irq_acc_ff;
    logic nxt_irq_acc;
    logic halt_rel_ff;
    logic nxt_halt_rel;
    logic [NUM_TAPS-1:0] taps_ff;
    logic [NUM_TAPS-1:0] nxt_taps;
    // bus state
    csp_bus_type bus_ff;
    csp_bus_type nxt_bus;
    logic wait_ff;
    logic nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic wr_acc;
    logic [FLD_W-1:0] set_bits;
    logic [FLD_W-1:0] clr_bits;

    // base oscillator: crystal or internal rc as a counted toggle, external rc from the pin
    always_comb begin
        nxt_osc_cnt = osc_cnt_ff;
        nxt_base = base_ff;
        nxt_ext = ext_rc_osc_in;
        if (USE_EXT) begin
            nxt_base = ext_ff;
        end else if (!(IS_CRYSTAL && stop_mode_in)) begin
            if (osc_cnt_ff == HALF_SEL - 12'h1) begin
                nxt_osc_cnt = 12'h0;
                nxt_base = ~base_ff;
            end else begin
                nxt_osc_cnt = osc_cnt_ff + 12'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_cnt_ff <= 12'h0;
            base_ff <= 1'b0;
            ext_ff <= 1'b0;
            base_prev_ff <= 1'b0;
        end else begin
            osc_cnt_ff <= nxt_osc_cnt;
            base_ff <= nxt_base;
            ext_ff <= nxt_ext;
            base_prev_ff <= base_ff;
        end
    end

    assign base_fall = base_prev_ff & ~base_ff;

    // divider input clock: base clock divided by the build ratio, an odd ratio above one rounded down to even
    always_comb begin
        nxt_pre_cnt = pre_cnt_ff;
        nxt_din = din_ff;
        if (PRE_DIV <= 1) begin
            nxt_din = base_ff;
        end else if (base_fall) begin
            if (pre_cnt_ff == PRE_HALF) begin
                nxt_pre_cnt = 4'h0;
                nxt_din = ~din_ff;
            end else begin
                nxt_pre_cnt = pre_cnt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_cnt_ff <= 4'h0;
            din_ff <= 1'b0;
            din_prev_ff <= 1'b0;
        end else begin
            pre_cnt_ff <= nxt_pre_cnt;
            din_ff <= nxt_din;
            din_prev_ff <= din_ff;
        end
    end

    // pre-divider steps on the falling input edge; clear instruction with its operand
    assign div_if.fall_en = din_prev_ff & ~din_ff;
    assign div_if.clr_upper = prescaler_clear_instruction_in && (clear_operand_in == CLR_OPERAND);

    csp_predivider u_predivider (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .div_io(div_if.div)
    );

    // peripheral clock taps
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TAPS; gi++) begin : g_tap
            assign nxt_taps[gi] = div_if.count[PERIPH_TAP[gi]];
        end
    endgenerate

    // halt-release request, flags and interrupt
    always_comb begin
        set_bits = '0;
        clr_bits = '0;
        set_bits[ST_HRF_BIT] = div_if.tap14_rise;
        set_bits[ST_WAKE_START_CONDITION_FLAG_BIT] = div_if.tap14_rise & ctrl_ff[CTRL_WAKE_EN_BIT];
        if (wr_acc && avs_address_in == REG_STATUS && avs_byteenable_in[0]) begin
            clr_bits = avs_writedata_in[FLD_W-1:0];
        end
        nxt_status = (status_ff & ~clr_bits) | set_bits;
        nxt_irq_acc = div_if.tap14_rise & ctrl_ff[CTRL_IRQ_EN_BIT];
        nxt_halt_rel = div_if.tap14_rise & ctrl_ff[CTRL_WAKE_EN_BIT];
        nxt_irq = |(nxt_status & nxt_mask);
    end

    // control and mask writes
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        if (wr_acc && avs_byteenable_in[0]) begin
            if (avs_address_in == REG_CTRL) begin
                nxt_ctrl = avs_writedata_in[FLD_W-1:0];
            end
            if (avs_address_in == REG_MASK) begin
                nxt_mask = avs_writedata_in[FLD_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_ff <= CTRL_RST;
            status_ff <= STATUS_RST;
            mask_ff <= MASK_RST;
            irq_ff <= 1'b0;
            irq_acc_ff <= 1'b0;
            halt_rel_ff <= 1'b0;
            taps_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            irq_ff <= nxt_irq;
            irq_acc_ff <= nxt_irq_acc;
            halt_rel_ff <= nxt_halt_rel;
            taps_ff <= nxt_taps;
        end
    end

    // avalon slave: one wait cycle, then accept
    assign wr_acc = (bus_ff == BUS_ACK) && avs_write_in;

    always_comb begin
        nxt_bus = bus_ff;
        nxt_wait = wait_ff;
        nxt_rdata = rdata_ff;
        case (bus_ff)
            BUS_IDLE: begin
                if (avs_read_in || avs_write_in) begin
                    nxt_bus = BUS_ACK;
                    nxt_wait = 1'b0;
                    nxt_rdata = 32'h0;
                    if (avs_read_in) begin
                        case (avs_address_in)
                            REG_CTRL: nxt_rdata[FLD_W-1:0] = ctrl_ff;
                            REG_STATUS: nxt_rdata[FLD_W-1:0] = status_ff;
                            REG_MASK: nxt_rdata[FLD_W-1:0] = mask_ff;
                            REG_COUNT: nxt_rdata[DIV_STAGES-1:0] = div_if.count;
                            default: nxt_rdata = 32'h0;
                        endcase
                    end
                end
            end
            BUS_ACK: begin
                nxt_bus = BUS_IDLE;
                nxt_wait = 1'b1;
            end
            default: begin
                nxt_bus = BUS_IDLE;
                nxt_wait = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_ff <= BUS_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            bus_ff <= nxt_bus;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs
    assign avs_readdata_out = rdata_ff;
    assign avs_waitrequest_out = wait_ff;
    assign periph_clk_out = taps_ff;
    assign divider_input_clock_out = din_ff;
    assign predivider_irq_out = irq_acc_ff;
    assign halt_release_out = halt_rel_ff;
    assign wake_start_condition_flag_out = status_ff[ST_WAKE_START_CONDITION_FLAG_BIT];
    assign irq_out = irq_ff;

    default clocking tck @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    chk_hrf_set: assert property (div_if.tap14_rise |=> status_ff[ST_HRF_BIT])
        else $error("release flag not set by tap request");
    chk_irq_accept: assert property (div_if.tap14_rise |=> predivider_irq_out == $past(ctrl_ff[CTRL_IRQ_EN_BIT]))
        else $error("interrupt acceptance does not follow enable");
    chk_wake_flag: assert property (div_if.tap14_rise && ctrl_ff[CTRL_WAKE_EN_BIT] |=> halt_release_out && wake_start_condition_flag_out)
        else $error("halt release or start flag missing");
    chk_no_wake: assert property (!(div_if.tap14_rise && ctrl_ff[CTRL_WAKE_EN_BIT]) |=> !halt_release_out)
        else $error("halt release without enabled request");
    chk_stop_freeze: assert property (IS_CRYSTAL && stop_mode_in [*2] |-> $stable(base_ff))
        else $error("crystal clock ran in stop mode");
    chk_prediv_edge: assert property (PRE_DIV > 1 && $changed(din_ff) |-> $past(base_fall))
        else $error("divider input moved without a base falling edge");
    chk_bus_answer: assert property (bus_ff == BUS_IDLE && (avs_read_in || avs_write_in) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not one wait cycle");
    chk_irq_level: assert property (irq_out == |(status_ff & mask_ff))
        else $error("interrupt output disagrees with status and mask");
    chk_tap_copy: assert property (##1 periph_clk_out[NUM_TAPS-1] == $past(div_if.count[PERIPH_TAP[NUM_TAPS-1]]))
        else $error("debounce tap not forwarded");
    cov_wake: cover property (div_if.tap14_rise && ctrl_ff[CTRL_WAKE_EN_BIT] ##1 halt_release_out);
    cov_irq: cover property (div_if.tap14_rise && ctrl_ff[CTRL_IRQ_EN_BIT] ##1 predivider_irq_out);
    cov_w1c: cover property (wr_acc && avs_address_in == REG_STATUS && status_ff != 2'h0);
endmodule // csp_top

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import csp_pkg::*;
    // shortened oscillator so the tap fires within a short run
    localparam int HALF_CYC = 2;
    localparam int STEP_CYC = 2 * HALF_CYC * PRE_DIV_DEFAULT;
    localparam int RATE_WIN = 400;
    localparam int TAP_WAIT = 40000;
    localparam int CYC_CEIL = 90000;
    // external rc pin half period and the divide ratio of the second build
    localparam int EXT_HALF = 4;
    localparam int RC_PRE = 4;
    localparam int RC_STEP = 2 * EXT_HALF * RC_PRE;
    typedef struct {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic [31:0] exp;
    } csp_row_type;
    // write then read back: address, data, byte enables, expected read
    csp_row_type rows [6] = '{
        '{REG_CTRL, 32'hffff_ffff, 4'hf, 32'h0000_0003},
        '{REG_CTRL, 32'h0000_0000, 4'he, 32'h0000_0003},
        '{REG_CTRL, 32'h0000_0000, 4'h1, 32'h0000_0000},
        '{REG_MASK, 32'hffff_ffff, 4'hf, 32'h0000_0003},
        '{REG_MASK, 32'h0000_0000, 4'hf, 32'h0000_0000},
        '{4'h2, 32'hffff_ffff, 4'hf, 32'h0000_0000}
    };
    logic ref_clk_in;
    logic rst_in;
    logic stop_mode_in;
    logic ext_rc_osc_in;
    logic prescaler_clear_instruction_in;
    logic [11:0] clear_operand_in;
    logic [3:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0] avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [NUM_TAPS-1:0] periph_clk_out;
    logic divider_input_clock_out;
    logic predivider_irq_out;
    logic halt_release_out;
    logic wake_start_condition_flag_out;
    logic irq_out;
    int fail_count;
    int checks;
    int cyc;
    int irq_hi;
    int halt_hi;
    int falls;
    int f0;
    int r0;
    int rc_falls;
    logic div_prev;
    logic rc_prev;
    logic rc_din;
    logic [NUM_TAPS-1:0] taps_seen;
    logic [NUM_TAPS-1:0] taps_exp;
    logic [31:0] rd;
    logic [31:0] cnt_a;
    logic [31:0] cnt_b;

    csp_top #(.CLK_SOURCE(SRC_CRYSTAL), .RC_RESISTOR(RES_INTERNAL), .RC_FREQ(RC_FREQ_350),
        .PRE_DIV(PRE_DIV_DEFAULT), .XTAL_HALF(HALF_CYC), .RC_350_HALF(HALF_CYC), .RC_650_HALF(HALF_CYC)) DUT (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .stop_mode_in(stop_mode_in), .ext_rc_osc_in(ext_rc_osc_in),
        .prescaler_clear_instruction_in(prescaler_clear_instruction_in), .clear_operand_in(clear_operand_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .periph_clk_out(periph_clk_out), .divider_input_clock_out(divider_input_clock_out),
        .predivider_irq_out(predivider_irq_out), .halt_release_out(halt_release_out),
        .wake_start_condition_flag_out(wake_start_condition_flag_out), .irq_out(irq_out));

    // second build: external-resistor rc source, input clock divided by four
    csp_top #(.CLK_SOURCE(SRC_RC), .RC_RESISTOR(RES_EXTERNAL), .RC_FREQ(RC_FREQ_650), .PRE_DIV(RC_PRE)) DUT_RC (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .stop_mode_in(stop_mode_in), .ext_rc_osc_in(ext_rc_osc_in),
        .prescaler_clear_instruction_in(prescaler_clear_instruction_in), .clear_operand_in(clear_operand_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(), .avs_waitrequest_out(), .periph_clk_out(), .divider_input_clock_out(rc_din),
        .predivider_irq_out(), .halt_release_out(), .wake_start_condition_flag_out(), .irq_out());

    // core clock, 10 ns period
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    // pulse widths, divider input falls and the hang guard
    always @(posedge ref_clk_in) begin
        cyc++;
        if (predivider_irq_out === 1'b1) irq_hi++;
        if (halt_release_out === 1'b1) halt_hi++;
        if (div_prev === 1'b1 && divider_input_clock_out === 1'b0) falls++;
        div_prev = divider_input_clock_out;
        if (rc_prev === 1'b1 && rc_din === 1'b0) rc_falls++;
        rc_prev = rc_din;
        ext_rc_osc_in <= 1'((cyc / EXT_HALF) % 2); // external rc oscillator level
        if (cyc == CYC_CEIL) begin
            $display("timeout after %0d cycles", cyc);
            fail_count++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string name);
        checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic test_end(input string name);
        $display("test %s done, mismatches so far %0d", name, fail_count);
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic avs_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
        input logic [3:0] be, output logic [31:0] rdata);
        avs_address_in <= addr;
        avs_writedata_in <= wd;
        avs_byteenable_in <= be;
        avs_read_in <= ~wr;
        avs_write_in <= wr;
        @(posedge ref_clk_in);
        while (avs_waitrequest_out !== 1'b0) begin
            @(posedge ref_clk_in);
        end
        rdata = avs_readdata_out;
        taps_seen = periph_clk_out; // taps stand with the count captured in rdata
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    // bounded wait for the debounce tap to reach a level
    task automatic wait_tap(input logic lvl);
        int n;
        n = 0;
        while (periph_clk_out[4] !== lvl && n < TAP_WAIT) begin
            @(posedge ref_clk_in);
            n++;
        end
        if (n == TAP_WAIT) fail_count++;
        repeat (5) @(posedge ref_clk_in);
    endtask

    task automatic clear_pulse(input logic [11:0] operand);
        clear_operand_in <= operand;
        prescaler_clear_instruction_in <= 1'b1;
        @(posedge ref_clk_in);
        prescaler_clear_instruction_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        {stop_mode_in, prescaler_clear_instruction_in, avs_read_in, avs_write_in} = 4'h0;
        {clear_operand_in, avs_address_in, avs_writedata_in, avs_byteenable_in} = '0;
        {fail_count, checks, cyc, irq_hi, halt_hi, falls, rc_falls} = '0;
        div_prev = 1'b0;
        rc_prev = 1'b0;
        rst_in = 1'b1;
        repeat (5) @(posedge ref_clk_in);
        check(avs_waitrequest_out, 1'b1, "waitrequest in reset");
        check(periph_clk_out, 5'h00, "taps in reset");
        check({irq_out, predivider_irq_out, halt_release_out}, 3'h0, "events in reset");
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        avs_xfer(1'b0, REG_STATUS, 32'h0, 4'hf, rd);
        check(rd, 32'h0, "status reset");
        test_end("reset");
        // register table rows
        foreach (rows[i]) begin
            avs_xfer(1'b1, rows[i].addr, rows[i].wdata, rows[i].be, rd);
            avs_xfer(1'b0, rows[i].addr, 32'h0, 4'hf, rd);
            check(rd, rows[i].exp, "register row");
        end
        test_end("registers");
        // divider rate, falling-edge advance, peripheral taps and the rc build
        f0 = falls;
        r0 = rc_falls;
        avs_xfer(1'b0, REG_COUNT, 32'h0, 4'hf, cnt_a);
        repeat (RATE_WIN) @(posedge ref_clk_in);
        avs_xfer(1'b0, REG_COUNT, 32'h0, 4'hf, cnt_b);
        for (int i = 0; i < NUM_TAPS; i++) taps_exp[i] = cnt_b[PERIPH_TAP[i]];
        check(taps_seen, taps_exp, "peripheral taps");
        check(cnt_a[31:15], 17'h0, "count width");
        check((cnt_b - cnt_a) >= RATE_WIN / STEP_CYC - 2 && (cnt_b - cnt_a) <= RATE_WIN / STEP_CYC + 4, 1'b1,
            "count rate");
        check((cnt_b - cnt_a) >= falls - f0 - 2 && (cnt_b - cnt_a) <= falls - f0 + 2, 1'b1, "steps per fall");
        check((rc_falls - r0) >= RATE_WIN / RC_STEP - 1 && (rc_falls - r0) <= RATE_WIN / RC_STEP + 2, 1'b1,
            "rc source rate");
        test_end("rate");
        // stop mode freezes the crystal source
        stop_mode_in <= 1'b1;
        repeat (10) @(posedge ref_clk_in);
        avs_xfer(1'b0, REG_COUNT, 32'h0, 4'hf, cnt_a);
        repeat (200) @(posedge ref_clk_in);
        avs_xfer(1'b0, REG_COUNT, 32'h0, 4'hf, cnt_b);
        check(cnt_b, cnt_a, "count in stop");
        stop_mode_in <= 1'b0;
        test_end("stop");
        // first tap event with both enables and the mask set
        avs_xfer(1'b1, REG_CTRL, 32'h3, 4'h1, rd);
        avs_xfer(1'b1, REG_MASK, 32'h1, 4'h1, rd);
        wait_tap(1'b1);
        check(irq_hi, 1, "irq pulses");
        check(halt_hi, 1, "halt release pulses");
        check(wake_start_condition_flag_out, 1'b1, "start flag");
        check(irq_out, 1'b1, "irq line");
        avs_xfer(1'b0, REG_STATUS, 32'h0, 4'hf, rd);
        check(rd, 32'h3, "status after tap");
        avs_xfer(1'b0, REG_COUNT, 32'h0, 4'hf, cnt_a);
        check(cnt_a[14:13], 2'b01, "count at tap");
        avs_xfer(1'b1, REG_STATUS, 32'h3, 4'h1, rd);
        avs_xfer(1'b0, REG_STATUS, 32'h0, 4'hf, rd);
        check(rd, 32'h0, "status cleared");
        check({irq_out, wake_start_condition_flag_out}, 2'b00, "lines cleared");
        test_end("tap one");
        // clear instruction: wrong operand ignored, right one clears upper stages
        clear_pulse(12'h101);
        avs_xfer(1'b0, REG_COUNT, 32'h0, 4'hf, cnt_a);
        check(cnt_a[13], 1'b1, "count after wrong operand");
        clear_pulse(CLR_OPERAND);
        avs_xfer(1'b0, REG_COUNT, 32'h0, 4'hf, cnt_a);
        check(cnt_a[14:10], 5'h00, "upper stages cleared");
        test_end("clear");
        // second tap event with enables and mask off
        avs_xfer(1'b1, REG_CTRL, 32'h0, 4'h1, rd);
        avs_xfer(1'b1, REG_MASK, 32'h0, 4'h1, rd);
        wait_tap(1'b0);
        wait_tap(1'b1);
        check({irq_hi[7:0], halt_hi[7:0]}, 16'h0101, "no pulses when disabled");
        avs_xfer(1'b0, REG_STATUS, 32'h0, 4'hf, rd);
        check(rd, 32'h1, "flag sets when disabled");
        check(irq_out, 1'b0, "masked irq line");
        avs_xfer(1'b1, REG_MASK, 32'h1, 4'h1, rd);
        avs_xfer(1'b0, REG_MASK, 32'h0, 4'hf, rd);
        check(irq_out, 1'b1, "unmasked irq line");
        avs_xfer(1'b1, REG_STATUS, 32'h1, 4'h1, rd);
        avs_xfer(1'b0, REG_STATUS, 32'h0, 4'hf, rd);
        check(irq_out, 1'b0, "irq line after clear");
        test_end("tap two");
        // reset in mid-run clears the upper stages
        rst_in <= 1'b1;
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        avs_xfer(1'b0, REG_COUNT, 32'h0, 4'hf, cnt_a);
        check(cnt_a[14:10], 5'h00, "count after reset");
        test_end("second reset");
        final_report();
    end
endmodule // tb_top
